// >>> shared/bmd_pkg.sv
// Address windows, boot pattern and mode codes for the board memory decoder
package bmd_pkg;
  localparam logic [15:0] EPROM_BASE     = 16'he800;
  localparam logic [15:0] RAM_TOP        = 16'he7ff;
  localparam logic [15:0] COMMON_TOP     = 16'h7fff;
  localparam logic [7:0]  USER_PAGE      = 8'hf6;
  localparam logic [7:0]  CAN_PAGE       = 8'hf7;
  localparam logic [4:0]  XRAM_PREFIX    = 5'h1f;
  localparam logic [7:0]  BOOT_PAGE      = 8'he8;
  localparam int          XRAM_MSB       = 15;
  localparam int          XRAM_LSB       = 11;
  localparam logic [2:0]  BANK_COMMON    = 3'h6;
  localparam logic [2:0]  BANK_USER_DATA = 3'h7;
  localparam logic [2:0]  BANK_APP_LAST  = 3'h5;
  localparam int          RAM_ADDR_W     = 18;
  typedef enum logic [2:0] {
    BMD_BOOT    = 3'b001,
    BMD_RUN     = 3'b010,
    BMD_MON_OFF = 3'b100
  } bmd_boot_type;
endpackage

// >>> logic/bmd_window_match.sv
// Address window comparator for the data-space chip selects
`timescale 1ns/1ps
module bmd_window_match (
  input  wire logic [15:0] addr,
  input  wire logic        data_cycle,
  input  wire logic        xram_unmap,
  output logic             sel_user,
  output logic             sel_can,
  output logic             in_xram
);
  always_comb begin
    sel_user = data_cycle && (addr[15:8] == bmd_pkg::USER_PAGE);
    sel_can  = data_cycle && (addr[15:8] == bmd_pkg::CAN_PAGE);
    // On-chip XRAM only when the mapping bit is cleared
    in_xram  = !xram_unmap &&
               (addr[bmd_pkg::XRAM_MSB:bmd_pkg::XRAM_LSB] ==
                bmd_pkg::XRAM_PREFIX);
  end
endmodule

// >>> logic/bmd_decoder.sv
// Board memory decoder: boot relocation, banking and chip selects
`timescale 1ns/1ps
// What this block does
// - Monitor on, switches off: RAM over 0000h-E7FFh, EPROM at code E800h-FFFFh.
// - Both switches on: three pins pick a bank for 8000h-E7FFh, 0000h-7FFFh common.
// - Data accesses to F700h-F7FFh select the CAN controller in all modes.
// - Data accesses to F600h-F6FFh assert the user chip select.
// - With the XRAM mapping bit clear, F800h-FFFFh data selects nothing outside.
// - In monitor mode RAM reads on either code fetch or data read strobe.
// - RAM space reaches 58 KB unbanked and 208 KB banked.
// - At reset EPROM answers every fetch; after the first fetch from page E8h it moves to E800h.
module bmd_decoder (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [15:0] addr,
  input  wire logic        code_fetch,
  input  wire logic        data_read,
  input  wire logic        data_write,
  input  wire logic        monitor_on,
  input  wire logic        bank_mode_switch_a,
  input  wire logic        bank_mode_switch_b,
  input  wire logic        onchip_xram_unmap_bit,
  input  wire logic        bank_select_low_pin,
  input  wire logic        bank_select_mid_pin,
  input  wire logic        bank_select_high_pin,
  output logic             cs_ram,
  output logic             cs_eprom,
  output logic             cs_can,
  output logic             cs_user,
  output logic             ram_read,
  output logic             ram_write,
  output logic [17:0]      ram_addr,
  output logic             monitor_running,
  output logic             bank_config_bad
);
  bmd_pkg::bmd_boot_type boot_reg;
  bmd_pkg::bmd_boot_type boot_next;
  logic cs_ram_reg, cs_ram_next;
  logic cs_eprom_reg, cs_eprom_next;
  logic cs_can_reg, cs_can_next;
  logic cs_user_reg, cs_user_next;
  logic ram_read_reg, ram_read_next;
  logic ram_write_reg, ram_write_next;
  logic [17:0] ram_addr_reg, ram_addr_next;
  logic bad_reg, bad_next;
  logic sel_user, sel_can, in_xram;
  logic data_cycle, banked;
  logic [2:0] bank;

  assign data_cycle = data_read || data_write;
  assign bank = {bank_select_high_pin, bank_select_mid_pin,
                 bank_select_low_pin};

  bmd_window_match u_match (
    .addr       (addr),
    .data_cycle (data_cycle),
    .xram_unmap (onchip_xram_unmap_bit),
    .sel_user   (sel_user),
    .sel_can    (sel_can),
    .in_xram    (in_xram)
  );

  // Boot state: EPROM everywhere until the first fetch from the boot page
  always_comb begin
    boot_next = boot_reg;
    unique case (boot_reg)
      bmd_pkg::BMD_BOOT: begin
        if (!monitor_on)
          boot_next = bmd_pkg::BMD_MON_OFF;
        else if (code_fetch && addr[15:8] == bmd_pkg::BOOT_PAGE)
          boot_next = bmd_pkg::BMD_RUN;
      end
      bmd_pkg::BMD_RUN: begin
        if (!monitor_on)
          boot_next = bmd_pkg::BMD_MON_OFF;
      end
      bmd_pkg::BMD_MON_OFF: begin
        if (monitor_on)
          boot_next = bmd_pkg::BMD_BOOT;
      end
      default: boot_next = bmd_pkg::BMD_BOOT;
    endcase
  end

  always_comb begin
    banked = bank_mode_switch_a && bank_mode_switch_b;
    // Mixed switch settings are flagged; mapping falls back to unbanked
    bad_next = bank_mode_switch_a ^ bank_mode_switch_b;
    cs_can_next  = sel_can && !in_xram;
    cs_user_next = sel_user && !in_xram;
    cs_eprom_next = 1'b0;
    cs_ram_next = 1'b0;
    ram_read_next = 1'b0;
    ram_write_next = 1'b0;
    ram_addr_next = {2'b00, addr};
    if (banked && addr > bmd_pkg::COMMON_TOP) begin
      // Banked window sits above the common 32 KB: 6.5 x 32 KB = 208 KB
      ram_addr_next = {bank, addr[14:0]};
    end else if (banked) begin
      ram_addr_next = {bmd_pkg::BANK_COMMON, addr[14:0]};
    end
    unique case (boot_reg)
      bmd_pkg::BMD_BOOT: begin
        cs_eprom_next = code_fetch;
      end
      bmd_pkg::BMD_RUN: begin
        if (addr >= bmd_pkg::EPROM_BASE) begin
          cs_eprom_next = code_fetch;
        end else begin
          // Code and data share one RAM, so writes alter code
          cs_ram_next = code_fetch || data_cycle;
          ram_read_next = code_fetch || data_read;
          ram_write_next = data_write;
        end
      end
      bmd_pkg::BMD_MON_OFF: begin
        cs_eprom_next = code_fetch;
        if (data_cycle && addr <= bmd_pkg::RAM_TOP) begin
          cs_ram_next = 1'b1;
          ram_read_next = data_read;
          ram_write_next = data_write;
        end
      end
      default: cs_eprom_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      boot_reg <= bmd_pkg::BMD_BOOT;
      cs_ram_reg <= 1'b0;
      cs_eprom_reg <= 1'b0;
      cs_can_reg <= 1'b0;
      cs_user_reg <= 1'b0;
      ram_read_reg <= 1'b0;
      ram_write_reg <= 1'b0;
      ram_addr_reg <= 18'h00000;
      bad_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      cs_ram_reg <= cs_ram_next;
      cs_eprom_reg <= cs_eprom_next;
      cs_can_reg <= cs_can_next;
      cs_user_reg <= cs_user_next;
      ram_read_reg <= ram_read_next;
      ram_write_reg <= ram_write_next;
      ram_addr_reg <= ram_addr_next;
      bad_reg <= bad_next;
    end
  end

  assign cs_ram = cs_ram_reg;
  assign cs_eprom = cs_eprom_reg;
  assign cs_can = cs_can_reg;
  assign cs_user = cs_user_reg;
  assign ram_read = ram_read_reg;
  assign ram_write = ram_write_reg;
  assign ram_addr = ram_addr_reg;
  assign monitor_running = (boot_reg == bmd_pkg::BMD_RUN);
  assign bank_config_bad = bad_reg;
endmodule

// >>> bench/bmd_decoder_props.sv
// Port checker for the board memory decoder
`timescale 1ns/1ps
module bmd_decoder_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [15:0] addr,
  input wire logic        code_fetch,
  input wire logic        data_read,
  input wire logic        data_write,
  input wire logic        monitor_on,
  input wire logic        bank_mode_switch_a,
  input wire logic        bank_mode_switch_b,
  input wire logic        onchip_xram_unmap_bit,
  input wire logic        bank_select_low_pin,
  input wire logic        bank_select_mid_pin,
  input wire logic        bank_select_high_pin,
  input wire logic        cs_ram,
  input wire logic        cs_eprom,
  input wire logic        cs_can,
  input wire logic        cs_user,
  input wire logic        ram_read,
  input wire logic        ram_write,
  input wire logic [17:0] ram_addr,
  input wire logic        monitor_running
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire acc = data_read | data_write;
  wire run = monitor_running & monitor_on;
  wire bnk = bank_mode_switch_a & bank_mode_switch_b;
  a_can_page: assert property (acc && addr[15:8] == 8'hf7 |=> cs_can)
    else $error("can select missed");
  a_can_only: assert property (cs_can |-> $past(addr[15:8]) == 8'hf7)
    else $error("can select outside its page");
  a_user_page: assert property (acc && addr[15:8] == 8'hf6 |=> cs_user)
    else $error("user select missed");
  a_xram_quiet: assert property (!onchip_xram_unmap_bit && acc &&
    addr[15:11] == 5'h1f |=> !(cs_can || cs_user || cs_ram))
    else $error("external select in on-chip range");
  a_boot_reloc: assert property (!monitor_running && monitor_on &&
    $past(monitor_on) && code_fetch && addr[15:8] == 8'he8
    |=> monitor_running)
    else $error("boot relocation missed");
  a_merged_read: assert property (run && (code_fetch || data_read) &&
    addr <= 16'he7ff && !(bank_mode_switch_a ^ bank_mode_switch_b)
    |=> ram_read && cs_ram)
    else $error("shared ram read missed");
  a_shared_write: assert property (run && data_write && !code_fetch &&
    !data_read && addr <= 16'he7ff |=> ram_write && cs_ram && !ram_read)
    else $error("shared ram write missed");
  a_eprom_top: assert property (run && code_fetch && addr >= 16'he800
    |=> cs_eprom && !cs_ram)
    else $error("monitor code window wrong");
  a_bank_addr: assert property (run && bnk && code_fetch && addr[15] &&
    addr <= 16'he7ff |=> ram_addr == {$past(bank_select_high_pin),
    $past(bank_select_mid_pin), $past(bank_select_low_pin), $past(addr[14:0])})
    else $error("banked ram address wrong");
endmodule
bind bmd_decoder bmd_decoder_props bmd_decoder_props_i (.*);

// >>> bench/bmd_cpu_model.sv
// Bus master model of the microcontroller side
`timescale 1ns/1ps
module bmd_cpu_model (
  input  wire logic        clk_sys,
  output logic [15:0]      addr,
  output logic             code_fetch,
  output logic             data_read,
  output logic             data_write
);
  initial {code_fetch, data_read, data_write, addr} = 19'h0;
  task drive(input logic [2:0] k, input logic [15:0] ad);
    {code_fetch, data_read, data_write} = k;
    // A released bus never repeats the stale address
    addr = (k == 3'h0) ? ~addr : ad;
  endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the board memory decoder
`timescale 1ns/1ps
module tb_top;
  typedef struct {time t; logic [24:0] m; logic [24:0] e;} bmd_note_type;
  logic         clk_sys, reset, monitor_on, onchip_xram_unmap_bit;
  logic         bank_mode_switch_a, bank_mode_switch_b, bank_select_low_pin;
  logic         bank_select_mid_pin, bank_select_high_pin;
  logic         code_fetch, data_read, data_write, cs_ram, cs_eprom;
  logic         cs_can, cs_user, ram_read, ram_write, monitor_running;
  logic         bank_config_bad;
  logic [15:0]  addr, ad;
  logic [17:0]  ram_addr;
  logic [31:0]  r;
  logic [2:0]   b;
  int           fails, cmp_count, seed, n;
  bmd_note_type q[$];
  wire [24:0] seen = {cs_ram, cs_eprom, cs_can, cs_user, ram_read,
                      monitor_running, bank_config_bad, ram_addr};
  bmd_decoder bmd_decoder_i (.*);
  bmd_cpu_model bmd_cpu_model_i (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task check(input logic [24:0] s, input logic [24:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Config c packs monitor, switch a, switch b, unmap bit, bank
  task step(input logic [6:0] c, input logic [2:0] k, input logic [15:0] a,
            input logic [24:0] m, input logic [24:0] e);
    #1;
    {monitor_on, bank_mode_switch_a, bank_mode_switch_b, onchip_xram_unmap_bit,
     bank_select_high_pin, bank_select_mid_pin, bank_select_low_pin} = c;
    bmd_cpu_model_i.drive(k, a);
    q.push_back('{$time, m, e});
    @(posedge clk_sys);
  endtask
  // Outputs land one edge after the inputs, so only older notes are due
  always @(negedge clk_sys) begin
    if (q.size() > 0 && q[0].t + 25 < $time) begin
      check(seen & q[0].m, q[0].e);
      void'(q.pop_front());
    end
  end
  initial begin
    seed = 42978;
    clk_sys = 1'b0;
    reset = 1'b1;
    {monitor_on, bank_mode_switch_a, bank_mode_switch_b} = 3'h4;
    {onchip_xram_unmap_bit, bank_select_high_pin} = 2'h0;
    {bank_select_mid_pin, bank_select_low_pin} = 2'h0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    step(7'h40, 3'h4, 16'he800, 25'h1880000, 25'h0880000);
    step(7'h40, 3'h4, 16'h0100, 25'h1980000, 25'h1180000);
    step(7'h40, 3'h2, 16'h0100, 25'h1980000, 25'h1180000);
    step(7'h40, 3'h1, 16'h0100, 25'h1980000, 25'h1080000);
    step(7'h40, 3'h4, 16'hf000, 25'h1880000, 25'h0880000);
    step(7'h40, 3'h2, 16'hf9a0, 25'h1600000, 25'h0000000);
    step(7'h60, 3'h4, 16'h0100, 25'h0040000, 25'h0040000);
    for (n = 0; n < 8; n++) begin
      r = $random(seed);
      b = 3'(r % 6);
      ad = {7'h7b, r[8:0]};
      step(7'h40, {1'b0, r[9], ~r[9]}, ad, 25'h0600000,
           r[8] ? 25'h0400000 : 25'h0200000);
      ad = {2'h2, r[29:16]};
      step({4'he, b}, 3'h4, ad, 25'h103ffff, {7'h40, b, ad[14:0]});
      ad = {1'b0, r[30:16]};
      step({4'he, b}, 3'h4, ad, 25'h103ffff, {10'h206, ad[14:0]});
    end
    // Monitor off: the first step still decodes with the running state
    step(7'h00, 3'h1, 16'h0200, 25'h1880000, 25'h1000000);
    step(7'h00, 3'h4, 16'h0100, 25'h1880000, 25'h0800000);
    for (n = 0; n < 10 && q.size() > 0; n++) @(posedge clk_sys);
    if (q.size() > 0)
      fails++;
    final_report();
  end
endmodule
